// File: logic/mit_pkg.sv
// Purpose: constants for the interrupt controller and time bases
// Assumes: APB slave, 32-bit data, byte addresses
// Notes: register map offsets are local choices where none exist
// Summary of operation
// [R1] External edge select: rising, falling, both, or disabled.
// [R2] Conversion done sets its flag; vector needs global and own enable.
// [R3] Servicing conversion clears its flag and global enable.
// [R4] Time base overflow sets its flag; vector needs global and own enable.
// [R5] No vector call while return stack is full.
// [R6] Servicing a time base clears its flag and global enable.
// [R7] Prescaler source: 00 sys, 01 sys/4, 10 sub clock, 11 crystal/8.
// [R8] Prescaler enable at bit 2; cleared stops prescaler output.
// [R9] Time base 0 uses prescaler 0, time base 1 prescaler 1.
// [R10] Period code selects 2^8 to 2^15 prescaler clocks.
// [R11] Time base runs only while bit 7 of its control is set.
// [R12] Serial module flag set on byte done, address match or time-out.
// [R13] Servicing serial module clears its flag and global enable.
// [R14] SPI byte done sets its flag; vector needs global and SPI enable.
// [R15] Servicing SPI clears its flag and global enable.
// [R16] Calendar flag set by time update, alarm or fixed-cycle timer.
// [R17] Servicing calendar clears its flag and global enable.
// [R18] Four grouped interrupts built from timer, low-voltage, EEPROM, UART.
// [R19] Group flag set whenever any included source flag becomes set; the code sets it only for a source whose own enable is set.
// [R20] Servicing group clears group flag only; software clears sources.
// [R21] Each timer raises compare A and compare P requests, own flag and enable.
// [R22] Flags set even with enable cleared; only vectoring suppressed.
// [R23] Rising edge of any flag requests wake-up, regardless of enables.
// [R24] Return-from-interrupt sets global enable; plain return leaves it.
// [R25] Simultaneous enabled requests granted one at a time by fixed priority.
package mit_pkg;
  // Byte offsets of registers
  localparam logic [7:0] MIT_PSC0_OFS = 8'h00;
  localparam logic [7:0] MIT_PSC1_OFS = 8'h04;
  localparam logic [7:0] MIT_TB0_OFS = 8'h08;
  localparam logic [7:0] MIT_TB1_OFS = 8'h0c;
  localparam logic [7:0] MIT_CTRL_OFS = 8'h10;
  localparam logic [7:0] MIT_FLAG_OFS = 8'h14;
  localparam logic [7:0] MIT_SRCF_OFS = 8'h18;
  localparam logic [7:0] MIT_SRCE_OFS = 8'h1c;
  localparam logic [7:0] MIT_GRANT_OFS = 8'h20;
  // Field positions
  localparam int MIT_PSC_ON_BIT = 2;
  localparam int MIT_TB_RUN_BIT = 7;
  localparam int MIT_GIE_BIT = 0;
  localparam int MIT_EDGE_LSB = 1;
  localparam int MIT_EN_LSB = 8;
  // Main vectored sources: ext, conv, tick0, tick1, serial, spi, calendar, group0..3
  localparam int MIT_NSRC = 11;
  localparam int MIT_I_EXT = 0;
  localparam int MIT_I_CONV = 1;
  localparam int MIT_I_TB0 = 2;
  localparam int MIT_I_TB1 = 3;
  localparam int MIT_I_SER = 4;
  localparam int MIT_I_SPI = 5;
  localparam int MIT_I_CAL = 6;
  localparam int MIT_I_GRP = 7;
  // Grouped sources: stm0..2 A/P, ptm0..1 A/P, lvd, eeprom, uart0, uart1
  localparam int MIT_NGSRC = 14;
  localparam logic [13:0] MIT_GRP0_MASK = 14'h003f;
  localparam logic [13:0] MIT_GRP1_MASK = 14'h03c0;
  localparam logic [13:0] MIT_GRP2_MASK = 14'h0c00;
  localparam logic [13:0] MIT_GRP3_MASK = 14'h3000;
  // Edge select codes
  localparam logic [1:0] MIT_EDGE_OFF = 2'h0;
  localparam logic [1:0] MIT_EDGE_RISE = 2'h1;
  localparam logic [1:0] MIT_EDGE_FALL = 2'h2;
  localparam logic [1:0] MIT_EDGE_BOTH = 2'h3;
  // Prescaler source codes
  localparam logic [1:0] MIT_SRC_SYS = 2'h0;
  localparam logic [1:0] MIT_SRC_SYS4 = 2'h1;
  localparam logic [1:0] MIT_SRC_SUB = 2'h2;
  localparam logic [1:0] MIT_SRC_LXT8 = 2'h3;
  localparam logic [1:0] MIT_SYS_DIV_LAST = 2'h3;
  localparam logic [2:0] MIT_LXT_DIV_LAST = 3'h7;
  localparam int MIT_PERIOD_BASE = 8;
  localparam int MIT_TB_CNT_W = 15;
  // Reset values
  localparam logic [7:0] MIT_CTRL8_RST = 8'h00;
endpackage : mit_pkg

// File: logic/mit_irq_ctrl.sv
// Purpose: interrupt request flags, grouped interrupts, time bases, APB regs
// Assumes: sub and crystal clocks and pins are asynchronous, synchronised here
// Notes: grant is a one-cycle pulse; vector code equals granted source index
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mit_irq_ctrl
  import mit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_pin,
  input wire logic sub_clk_pin,
  input wire logic lxt_clk_pin,
  input wire logic conv_done,
  input wire logic serial_byte_done,
  input wire logic serial_addr_match,
  input wire logic serial_timeout,
  input wire logic spi_byte_done,
  input wire logic cal_update,
  input wire logic cal_alarm,
  input wire logic cal_cycle,
  input wire logic [MIT_NGSRC-1:0] group_src_event,
  input wire logic stack_full,
  input wire logic grant_ready,
  input wire logic return_from_irq,
  output logic irq_grant,
  output logic [3:0] irq_vector,
  output logic wake_req
);
  logic [2:0] ext_sync_q;
  logic [1:0] sub_sync_q;
  logic sub_prev_q;
  logic [1:0] lxt_sync_q;
  logic lxt_prev_q;
  logic [1:0] sys_div_q;
  logic [2:0] lxt_div_q;
  logic [7:0] psc_q [2];
  logic [7:0] tbc_q [2];
  logic [MIT_TB_CNT_W-1:0] tb_cnt_q [2];
  logic [1:0] tb_ovf;
  logic [1:0] psc_tick;
  logic gie_q;
  logic [1:0] ext_edge_select_q;
  logic [MIT_NSRC-1:0] en_q;
  logic [MIT_NSRC-1:0] flag_q;
  logic [MIT_NSRC-1:0] flag_prev_q;
  logic [MIT_NSRC-1:0] flag_set;
  logic [MIT_NSRC-1:0] svc_clr;
  logic [MIT_NSRC-1:0] sw_clr;
  logic [MIT_NGSRC-1:0] gsrc_flag_q;
  logic [MIT_NGSRC-1:0] gsrc_en_q;
  logic [MIT_NGSRC-1:0] gsrc_set;
  logic [MIT_NGSRC-1:0] gsrc_prev_q;
  logic [MIT_NGSRC-1:0] gsrc_clr;
  logic [13:0] grp_mask [4];
  logic ext_rise;
  logic ext_fall;
  logic ext_hit;
  logic [MIT_NSRC-1:0] pend;
  logic grant_d;
  logic [3:0] vec_d;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata_d;
  logic addr_ok;

  assign grp_mask[0] = MIT_GRP0_MASK;
  assign grp_mask[1] = MIT_GRP1_MASK;
  assign grp_mask[2] = MIT_GRP2_MASK;
  assign grp_mask[3] = MIT_GRP3_MASK;

  // Two-stage synchronisers; third stage of pin feeds edge detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync_q <= 3'h0;
      sub_sync_q <= 2'h0;
      sub_prev_q <= 1'b0;
      lxt_sync_q <= 2'h0;
      lxt_prev_q <= 1'b0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[1:0], ext_pin};
      sub_sync_q <= {sub_sync_q[0], sub_clk_pin};
      sub_prev_q <= sub_sync_q[1];
      lxt_sync_q <= {lxt_sync_q[0], lxt_clk_pin};
      lxt_prev_q <= lxt_sync_q[1];
    end
  end

  // External edge qualification
  assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  assign ext_fall = ~ext_sync_q[1] & ext_sync_q[2];
  always_comb
  begin
    case (ext_edge_select_q) // see [R1]
      MIT_EDGE_OFF: ext_hit = 1'b0;
      MIT_EDGE_RISE: ext_hit = ext_rise;
      MIT_EDGE_FALL: ext_hit = ext_fall;
      MIT_EDGE_BOTH: ext_hit = ext_rise | ext_fall;
      default: ext_hit = 1'b0;
    endcase
  end

  // Shared source dividers for sys/4 and crystal/8
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_div_q <= 2'h0;
      lxt_div_q <= 3'h0;
    end
    else
    begin
      sys_div_q <= sys_div_q + 2'h1;
      if (lxt_sync_q[1] & ~lxt_prev_q)
        lxt_div_q <= lxt_div_q + 3'h1;
    end
  end

  // Prescalers and time bases, one per channel
  for (genvar i = 0; i < 2; i++)
  begin : g_tb
    logic raw_tick;
    logic [MIT_TB_CNT_W-1:0] last;
    always_comb
    begin
      case (psc_q[i][1:0]) // see [R7]
        MIT_SRC_SYS: raw_tick = 1'b1;
        MIT_SRC_SYS4: raw_tick = (sys_div_q == MIT_SYS_DIV_LAST);
        MIT_SRC_SUB: raw_tick = sub_sync_q[1] & ~sub_prev_q;
        MIT_SRC_LXT8: raw_tick = lxt_sync_q[1] & ~lxt_prev_q & (lxt_div_q == MIT_LXT_DIV_LAST);
        default: raw_tick = 1'b0;
      endcase
    end
    assign psc_tick[i] = raw_tick & psc_q[i][MIT_PSC_ON_BIT]; // see [R8] [R9]
    // Period 2^(8+code) ticks
    assign last = MIT_TB_CNT_W'((32'h1 << (MIT_PERIOD_BASE + int'(tbc_q[i][2:0]))) - 32'h1); // see [R10]
    assign tb_ovf[i] = tbc_q[i][MIT_TB_RUN_BIT] & psc_tick[i] & (tb_cnt_q[i] >= last);
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        tb_cnt_q[i] <= '0;
      else if (!tbc_q[i][MIT_TB_RUN_BIT]) // see [R11]
        tb_cnt_q[i] <= '0;
      else if (tb_ovf[i])
        tb_cnt_q[i] <= '0;
      else if (psc_tick[i])
        tb_cnt_q[i] <= tb_cnt_q[i] + 1'b1;
    end
  end

  // APB decode; zero wait states
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    addr_ok = 1'b1;
    rdata_d = 32'h0;
    case (paddr)
      MIT_PSC0_OFS: rdata_d = {24'h0, psc_q[0]};
      MIT_PSC1_OFS: rdata_d = {24'h0, psc_q[1]};
      MIT_TB0_OFS: rdata_d = {24'h0, tbc_q[0]};
      MIT_TB1_OFS: rdata_d = {24'h0, tbc_q[1]};
      MIT_CTRL_OFS: rdata_d = {13'h0, en_q, 5'h0, ext_edge_select_q, gie_q};
      MIT_FLAG_OFS: rdata_d = {21'h0, flag_q};
      MIT_SRCF_OFS: rdata_d = {18'h0, gsrc_flag_q};
      MIT_SRCE_OFS: rdata_d = {18'h0, gsrc_en_q};
      MIT_GRANT_OFS: rdata_d = {28'h0, irq_vector};
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // Read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite)
      prdata <= rdata_d;
  end

  // Configuration registers; unused bits read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      psc_q[0] <= MIT_CTRL8_RST;
      psc_q[1] <= MIT_CTRL8_RST;
      tbc_q[0] <= MIT_CTRL8_RST;
      tbc_q[1] <= MIT_CTRL8_RST;
      ext_edge_select_q <= MIT_EDGE_OFF;
      en_q <= '0;
      gsrc_en_q <= '0;
    end
    else if (wr_en)
    begin
      case (paddr)
        MIT_PSC0_OFS: psc_q[0] <= {5'h0, pwdata[2:0]};
        MIT_PSC1_OFS: psc_q[1] <= {5'h0, pwdata[2:0]};
        MIT_TB0_OFS: tbc_q[0] <= {pwdata[MIT_TB_RUN_BIT], 4'h0, pwdata[2:0]};
        MIT_TB1_OFS: tbc_q[1] <= {pwdata[MIT_TB_RUN_BIT], 4'h0, pwdata[2:0]};
        MIT_CTRL_OFS:
        begin
          ext_edge_select_q <= pwdata[MIT_EDGE_LSB +: 2];
          en_q <= pwdata[MIT_EN_LSB +: MIT_NSRC];
        end
        MIT_SRCE_OFS: gsrc_en_q <= pwdata[MIT_NGSRC-1:0];
        default: ;
      endcase
    end
  end

  // Grouped source flags; set wins over software clear, never auto-cleared
  assign gsrc_set = group_src_event; // see [R21] [R22]
  assign gsrc_clr = (wr_en && paddr == MIT_SRCF_OFS) ? pwdata[MIT_NGSRC-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gsrc_flag_q <= '0;
      gsrc_prev_q <= '0;
    end
    else
    begin
      gsrc_flag_q <= (gsrc_flag_q & ~gsrc_clr) | gsrc_set; // see [R20]
      gsrc_prev_q <= gsrc_flag_q;
    end
  end

  // Event sources for the main flags
  always_comb
  begin
    flag_set = '0;
    flag_set[MIT_I_EXT] = ext_hit;
    flag_set[MIT_I_CONV] = conv_done; // see [R2]
    flag_set[MIT_I_TB0] = tb_ovf[0]; // see [R4]
    flag_set[MIT_I_TB1] = tb_ovf[1];
    flag_set[MIT_I_SER] = serial_byte_done | serial_addr_match | serial_timeout; // see [R12]
    flag_set[MIT_I_SPI] = spi_byte_done; // see [R14]
    flag_set[MIT_I_CAL] = cal_update | cal_alarm | cal_cycle; // see [R16]
    for (int g = 0; g < 4; g++)
      flag_set[MIT_I_GRP+g] = |(gsrc_flag_q & ~gsrc_prev_q & gsrc_en_q & grp_mask[g]); // see [R18] [R19]
  end

  // Pending and fixed priority grant, lowest index first
  assign pend = flag_q & en_q;
  always_comb
  begin
    grant_d = 1'b0;
    vec_d = 4'h0;
    svc_clr = '0;
    if (gie_q && !stack_full && grant_ready && !irq_grant) // see [R5]
    begin
      for (int k = MIT_NSRC-1; k >= 0; k--)
      begin
        if (pend[k])
        begin
          grant_d = 1'b1;
          vec_d = 4'(k);
        end
      end
      if (grant_d)
        svc_clr[vec_d] = 1'b1; // see [R25]
    end
  end

  // Main flags: hardware set wins over service or software clear
  assign sw_clr = (wr_en && paddr == MIT_FLAG_OFS) ? pwdata[MIT_NSRC-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q <= '0;
      flag_prev_q <= '0;
    end
    else
    begin
      flag_q <= (flag_q & ~svc_clr & ~sw_clr) | flag_set; // see [R3] [R6] [R13] [R15] [R17] [R20] [R22]
      flag_prev_q <= flag_q;
    end
  end

  // Global enable: service clears, return-from-irq sets, software writes either value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gie_q <= 1'b0;
    else if (grant_d)
      gie_q <= 1'b0; // see [R3] [R6]
    else if (return_from_irq)
      gie_q <= 1'b1; // see [R24]
    else if (wr_en && paddr == MIT_CTRL_OFS)
      gie_q <= pwdata[MIT_GIE_BIT];
  end

  // Grant outputs and wake-up request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_grant <= 1'b0;
      irq_vector <= 4'h0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq_grant <= grant_d;
      if (grant_d)
        irq_vector <= vec_d;
      wake_req <= |(flag_q & ~flag_prev_q) | |(gsrc_flag_q & ~gsrc_prev_q); // see [R23]
    end
  end

  // Checks
  stall_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    stack_full |=> !irq_grant) else $error("grant while stack full"); // see [R5]
  grant_gie_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_grant |-> !gie_q) else $error("global enable not cleared on service"); // see [R3]
  grant_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    grant_d && !flag_set[vec_d] |=> !flag_q[irq_vector]) else $error("flag not cleared"); // see [R6]
  event_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done |=> flag_q[MIT_I_CONV]) else $error("conversion flag missed"); // see [R22]
  return_from_irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    return_from_irq && !grant_d && !wr_en |=> gie_q) else $error("return did not enable"); // see [R24]
  wake_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_q[MIT_I_SPI]) |=> wake_req) else $error("no wake on flag rise"); // see [R23]
  tb_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tbc_q[0][MIT_TB_RUN_BIT] |-> !tb_ovf[0] ##1 tb_cnt_q[0] == '0) else $error("time base runs while off"); // see [R11]
  psc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psc_q[0][MIT_PSC_ON_BIT] && tbc_q[0][MIT_TB_RUN_BIT] |=> $stable(tb_cnt_q[0]))
    else $error("prescaler ticks while off"); // see [R8]
  src_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    gsrc_flag_q[0] && gsrc_clr == '0 |=> gsrc_flag_q[0]) else $error("source flag auto-cleared"); // see [R20]
endmodule : mit_irq_ctrl
`default_nettype wire

// File: testbench/mit_cpu_model.sv
// Purpose: CPU sequencer model facing the interrupt block
// Assumes: each grant pushes one return address
// Notes: slow mode takes a vector one cycle in four
`timescale 1ns/1ps
`default_nettype none
module mit_cpu_model #(
  parameter int DEPTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_grant,
  input wire logic ret_req,
  input wire logic slow,
  output logic stack_full,
  output logic grant_ready,
  output logic return_from_irq
);
  logic [3:0] depth_q;
  logic [1:0] phase_q;
  // Stack depth, return pulse and accept phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      depth_q <= 4'h0;
      phase_q <= 2'h0;
      return_from_irq <= 1'b0;
    end
    else
    begin
      depth_q <= depth_q + 4'(irq_grant) - 4'(return_from_irq);
      phase_q <= phase_q + 2'h1;
      return_from_irq <= ret_req && depth_q != 4'h0;
    end
  end
  // Full stack blocks vectoring
  assign stack_full = depth_q >= 4'(DEPTH);
  assign grant_ready = !slow || phase_q == 2'h0;
endmodule : mit_cpu_model
`default_nettype wire

// File: testbench/mcu_interrupt_and_time_base_bench.sv
// Purpose: self-checking bench for the interrupt block
// Assumes: zero-wait APB slave, slow clocks free running
// Notes: tick periods measured between wake pulses
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_and_time_base_bench
  import mit_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_pin = 1'b0;
  logic sub_clk_pin = 1'b0, lxt_clk_pin = 1'b0, ret_req = 1'b0, slow = 1'b0, se;
  logic pready, pslverr, stack_full, grant_ready, return_from_irq, irq_grant, wake_req;
  logic [7:0] paddr = 8'h00, ev = 8'h00;
  logic [13:0] gev = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, sr;
  logic [3:0] irq_vector;
  int n_fail = 0, checks = 0, cyc = 0, last_wake = 0, n_wake = 0;

  // System, sub and crystal clocks
  always #2 pclk = ~pclk;
  always #16 sub_clk_pin = ~sub_clk_pin;
  always #12 lxt_clk_pin = ~lxt_clk_pin;

  mit_irq_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
    .sub_clk_pin(sub_clk_pin), .lxt_clk_pin(lxt_clk_pin), .conv_done(ev[0]), .serial_byte_done(ev[1]),
    .serial_addr_match(ev[2]), .serial_timeout(ev[3]), .spi_byte_done(ev[4]), .cal_update(ev[5]),
    .cal_alarm(ev[6]), .cal_cycle(ev[7]), .group_src_event(gev), .stack_full(stack_full),
    .grant_ready(grant_ready), .return_from_irq(return_from_irq), .irq_grant(irq_grant),
    .irq_vector(irq_vector), .wake_req(wake_req)
  );

  mit_cpu_model #(.DEPTH(1)) cpu (
    .pclk(pclk), .presetn(presetn), .irq_grant(irq_grant), .ret_req(ret_req), .slow(slow),
    .stack_full(stack_full), .grant_ready(grant_ready), .return_from_irq(return_from_irq)
  );

  // Cycle count and wake pulse log
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1)
    begin
      last_wake <= cyc;
      n_wake <= n_wake + 1;
    end
  end

  // Verdict and end of run
  task wrap_up;
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Compare and log
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    sr = prdata;
    se = pslverr;
    if (n >= 50)
    begin
      n_fail++;
      $display("[ERR] pready expected 1 seen 0");
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Read and compare
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, sr);
  endtask : rd

  // One-cycle event pulses
  task pulse(input logic [7:0] e, input logic [13:0] g);
    ev <= e;
    gev <= g;
    @(posedge pclk);
    ev <= 8'h00;
    gev <= 14'h0;
    @(posedge pclk);
  endtask : pulse

  // Bounded wait for a grant, then its vector
  task wait_grant(input logic [3:0] v);
    int n;
    n = 0;
    while (irq_grant !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk("irq_grant", 32'h1, {31'h0, irq_grant});
    chk("irq_vector", {28'h0, v}, {28'h0, irq_vector});
  endtask : wait_grant

  // No grant for n cycles
  task no_grant(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      chk("no grant", 32'h0, {31'h0, irq_grant});
    end
  endtask : no_grant

  // Return from the service routine
  task ret;
    ret_req <= 1'b1;
    @(posedge pclk);
    ret_req <= 1'b0;
    @(posedge pclk);
  endtask : ret

  // Bounded wait for a new wake pulse, result in se
  task wait_wake(input int lim);
    int n0, n;
    n0 = n_wake;
    n = 0;
    while (n_wake == n0 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    se = n_wake != n0;
  endtask : wait_wake

  // Reset values, unused bits, unmapped address
  task t_regs;
    rd("psc0", MIT_PSC0_OFS, 32'h0);
    rd("psc1", MIT_PSC1_OFS, 32'h0);
    rd("tb0", MIT_TB0_OFS, 32'h0);
    rd("tb1", MIT_TB1_OFS, 32'h0);
    apb(1'b1, MIT_PSC1_OFS, 32'hff);
    rd("psc1 bits", MIT_PSC1_OFS, 32'h7);
    apb(1'b1, MIT_TB0_OFS, 32'hff);
    rd("tb0 bits", MIT_TB0_OFS, 32'h87);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, se});
    chk("unmapped data", 32'h0, sr);
    apb(1'b1, MIT_PSC1_OFS, 32'h0);
    apb(1'b1, MIT_TB0_OFS, 32'h0);
  endtask : t_regs

  // Flag and wake with every enable off
  task t_flag_wake;
    int n0;
    n0 = n_wake;
    apb(1'b1, MIT_CTRL_OFS, 32'h0);
    pulse(8'h01, 14'h0);
    no_grant(4);
    chk("wake count", 32'(n0 + 1), 32'(n_wake));
    rd("flag pending", MIT_FLAG_OFS, 32'h2);
  endtask : t_flag_wake

  // Full stack holds a request until a return
  task t_stack;
    apb(1'b1, MIT_CTRL_OFS, 32'h201);
    wait_grant(4'h1);
    rd("gie cleared", MIT_CTRL_OFS, 32'h200);
    pulse(8'h10, 14'h0);
    apb(1'b1, MIT_CTRL_OFS, 32'h2001);
    no_grant(20);
    ret;
    wait_grant(4'h5);
    ret;
    rd("gie returned", MIT_CTRL_OFS, 32'h2001);
  endtask : t_stack

  // Every event input of the conversion, serial, SPI and calendar sources
  task t_sources;
    logic [3:0] v;
    for (int k = 0; k < 8; k++)
    begin
      v = k == 0 ? 4'h1 : k < 4 ? 4'h4 : k == 4 ? 4'h5 : 4'h6;
      apb(1'b1, MIT_CTRL_OFS, 32'h1 | 32'h1 << (8 + v));
      pulse(8'h1 << k, 14'h0);
      wait_grant(v);
      rd("flags", MIT_FLAG_OFS, 32'h0);
      rd("gie", MIT_CTRL_OFS, 32'h1 << (8 + v));
      ret;
    end
  endtask : t_sources

  // Two pending requests with a slow sequencer
  task t_priority;
    apb(1'b1, MIT_CTRL_OFS, 32'h0);
    slow <= 1'b1;
    pulse(8'h10, 14'h0);
    pulse(8'h01, 14'h0);
    apb(1'b1, MIT_CTRL_OFS, 32'h2201);
    wait_grant(4'h1);
    ret;
    wait_grant(4'h5);
    ret;
    slow <= 1'b0;
  endtask : t_priority

  // Grouped interrupts leave source flags set
  task t_groups;
    int s;
    for (int i = 0; i < 4; i++)
    begin
      s = i == 0 ? 1 : i == 1 ? 6 : i == 2 ? 11 : 12;
      apb(1'b1, MIT_SRCE_OFS, 32'h1 << s);
      apb(1'b1, MIT_CTRL_OFS, 32'h1 | 32'h1 << (15 + i));
      pulse(8'h0, 14'h1 << s);
      wait_grant(4'(7 + i));
      rd("group flag", MIT_FLAG_OFS, 32'h0);
      rd("source flag", MIT_SRCF_OFS, 32'h1 << s);
      apb(1'b1, MIT_SRCF_OFS, 32'h1 << s);
      rd("source clear", MIT_SRCF_OFS, 32'h0);
      ret;
    end
  endtask : t_groups

  // All four edge select codes
  task t_edges;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, MIT_CTRL_OFS, 32'(c << 1));
      ext_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      rd("edge rise", MIT_FLAG_OFS, 32'(c % 2));
      apb(1'b1, MIT_FLAG_OFS, 32'h1);
      ext_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      rd("edge fall", MIT_FLAG_OFS, 32'(c / 2));
      apb(1'b1, MIT_FLAG_OFS, 32'h1);
    end
  endtask : t_edges

  // Tick periods per source and code, then stopped ticks
  task t_tick;
    int src, code, exp, d;
    logic tb;
    for (int j = 0; j < 5; j++)
    begin
      tb = j == 2 || j == 4;
      src = j == 2 ? 0 : j == 4 ? 3 : j == 3 ? 2 : j;
      code = j == 2;
      exp = (256 << code) * (src == 0 ? 4 : src == 1 ? 16 : src == 2 ? 32 : 192) / 4;
      apb(1'b1, tb ? MIT_PSC1_OFS : MIT_PSC0_OFS, 32'h4 | 32'(src));
      apb(1'b1, tb ? MIT_TB1_OFS : MIT_TB0_OFS, 32'h80 | 32'(code));
      wait_wake(20000);
      d = last_wake;
      apb(1'b1, MIT_FLAG_OFS, 32'h4 << tb);
      wait_wake(20000);
      d = last_wake - d;
      if (src > 1 && d - exp <= 8 && exp - d <= 8)
        d = exp;
      chk("tick period", 32'(exp), 32'(d));
      apb(1'b1, tb ? MIT_TB1_OFS : MIT_TB0_OFS, 32'h0);
      apb(1'b1, MIT_FLAG_OFS, 32'hc);
    end
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, MIT_PSC0_OFS, 32'(4 * m));
      apb(1'b1, MIT_TB0_OFS, 32'(128 * (1 - m)));
      wait_wake(700);
      chk("tick stopped", 32'h0, {31'h0, se});
    end
  endtask : t_tick

  // Reset, then every scenario
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_flag_wake;
    t_stack;
    t_sources;
    t_priority;
    t_groups;
    t_edges;
    t_tick;
    wrap_up;
  end

  // Watchdog against a hung wait
  initial
  begin
    #300000;
    n_fail++;
    wrap_up;
  end
endmodule : mcu_interrupt_and_time_base_bench
`default_nettype wire
